//--- common/pgm_defs.svh
// constants of the pin gating and probe mux block: offsets, field positions,
// reset values and selector limits.
// assumes a byte-addressed register port of 8 address bits and 32 data bits.
`ifndef PGM_DEFS_SVH
`define PGM_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define PGM_OFS_CTRL0        8'h00
`define PGM_OFS_CTRL1        8'h04
`define PGM_OFS_CTRL2        8'h08
`define PGM_OFS_STATUS       8'h3C

// ****************************************************************
// control 0 field positions
// ****************************************************************
`define PGM_BIT_SESSION_SW   19
`define PGM_BIT_SESSION_SRC  18
`define PGM_BIT_OUT_RST      14
`define PGM_BIT_IN_PWR       13
`define PGM_BIT_OUT_PWR      12
`define PGM_BIT_IN_BAT       11
`define PGM_BIT_OUT_BAT      10

// ****************************************************************
// control 2 field positions and selector limits
// ****************************************************************
`define PGM_DMA_SEL_HI       18
`define PGM_DMA_SEL_LO       13
`define PGM_IRQ_SEL_HI       12
`define PGM_IRQ_SEL_LO       6
`define PGM_DMA_SEL_MAX      50
`define PGM_IRQ_SEL_MAX      101

// ****************************************************************
// status field positions
// ****************************************************************
`define PGM_BIT_ST_SESSION   0
`define PGM_BIT_ST_DMA_ON    1
`define PGM_BIT_ST_IRQ_ON    2

// ****************************************************************
// reset values
// ****************************************************************
`define PGM_RST_CTRL0        7'h00
`define PGM_RST_DMA_SEL      6'h00
`define PGM_RST_IRQ_SEL      7'h00
`define PGM_RST_RDATA        32'h00000000

`endif

//--- common/pgm_pkg.sv
// types of the pin gating and probe mux block.
// assumes pgm_defs.svh for the field positions used to fill them.
package pgm_pkg;

	// control 0 fields, in register bit order from 19 down to 10
	typedef struct packed {
		logic session_sw;   // software session level
		logic session_src;  // 1: software level drives the usb core
		logic out_gate_rst; // outputs and-gated with reset-out
		logic in_gate_pwr;  // inputs and-gated with comm pins
		logic out_gate_pwr; // outputs and-gated with comm pins
		logic in_gate_bat;  // inputs and-gated with battery-fail pin
		logic out_gate_bat; // outputs and-gated with battery-fail pin
	} pgm_ctrl0_type;

	// control 2 selectors
	typedef struct packed {
		logic [5:0] dma_sel; // dma request probe select
		logic [6:0] irq_sel; // interrupt probe select
	} pgm_probe_sel_type;

endpackage

//--- rtl/pgm_and_gate.sv
// registered and-gate: data pass while every enabled gate level is high.
// assumes levels and data synchronous to clk_sys_i.
`timescale 1ns/1ps

module pgm_and_gate #(
	parameter int W = 8, // data width
	parameter int K = 2  // number of gate terms
) (
	input  wire logic         clk_sys_i,  // system clock
	input  wire logic         sys_rst_i,  // sync reset, active high
	input  wire logic [W-1:0] data_i,     // ungated data
	input  wire logic [K-1:0] gate_en_i,  // per-term enable
	input  wire logic [K-1:0] gate_lvl_i, // per-term gating level
	output logic      [W-1:0] data_o      // gated data, registered
);

	logic         pass;
	logic [W-1:0] data_ff;

	// a disabled term never blocks
	assign pass = &(~gate_en_i | gate_lvl_i);

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			data_ff <= '0;
		else
			data_ff <= pass ? data_i : '0;
	end

	assign data_o = data_ff;

endmodule

//--- rtl/pgm_probe_mux.sv
// one probe pin: selector 0 or above SRC_N keeps the normal function,
// otherwise source bit sel-1 is driven out with the enable high.
// assumes sources synchronous to clk_sys_i.
`timescale 1ns/1ps

module pgm_probe_mux #(
	parameter int SRC_N = 50, // number of observable sources
	parameter int SEL_W = 6   // selector width
) (
	input  wire logic             clk_sys_i,  // system clock
	input  wire logic             sys_rst_i,  // sync reset, active high
	input  wire logic [SEL_W-1:0] sel_i,      // probe selector
	input  wire logic [SRC_N-1:0] src_i,      // source k at bit k-1
	input  wire logic             norm_out_i, // normal-function level
	input  wire logic             norm_oe_i,  // normal-function enable
	output logic                  pin_o,      // pin level, registered
	output logic                  pin_oe_o,   // pin enable, registered
	output logic                  probe_on_o  // probe active, registered
);

	logic             live;
	logic [SEL_W-1:0] idx;
	logic             out_ff;
	logic             oe_ff;
	logic             on_ff;

	// out-of-range codes fall back to normal function
	assign live = (sel_i != '0) && (sel_i <= SEL_W'(SRC_N));
	assign idx  = sel_i - SEL_W'(1);

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			out_ff <= 1'b0;
			oe_ff  <= 1'b0;
			on_ff  <= 1'b0;
		end
		else
		begin
			out_ff <= live ? src_i[idx] : norm_out_i;
			oe_ff  <= live | norm_oe_i;
			on_ff  <= live;
		end
	end

	assign pin_o      = out_ff;
	assign pin_oe_o   = oe_ff;
	assign probe_on_o = on_ff;

endmodule

//--- rtl/pgm_top.sv
// pin gating and probe mux: usb session source, and-gating of chip pins,
// and two observability probes on spare uart pins.
// assumes all inputs synchronous to clk_sys_i and a simple register port.
//
// Contract
// - software session bit gives insertion or disconnection
// - bit 18 selects hardware or software session
// - bit 14 gates outputs with reset-out
// - bit 13 gates inputs with comm pins
// - bit 12 gates outputs with comm pins
// - bit 11 gates inputs with battery-fail pin
// - bit 10 gates outputs with battery-fail pin
// - control 0 acts in every mode
// - dma selector bits 18-13, values 0 to 50
// - dma values 1-19 probe dsp requests
// - dma values 20-50 probe system requests
// - irq selector bits 12-6, values 0 to 101
// - irq values 1-16 probe dsp level-2
// - irq values 17-37 probe dsp level-1
// - irq values 38-69 probe mpu level-1
// - irq values 70-101 probe mpu level-2
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pgm_defs.svh"

module pgm_top #(
	parameter int IN_W  = 8, // gated chip inputs
	parameter int OUT_W = 8  // gated chip outputs
) (
	input  wire logic             clk_sys_i,                   // system clock
	input  wire logic             sys_rst_i,                   // sync reset
	input  wire logic [7:0]       reg_addr_i,                  // byte address
	input  wire logic [31:0]      reg_wdata_i,                 // write data
	input  wire logic             reg_wr_i,                    // write strobe
	input  wire logic             reg_rd_i,                    // read strobe
	output logic      [31:0]      reg_rdata_o,                 // read data
	input  wire logic             usb_hw_session_i,            // hw detect
	output logic                  usb_session_o,               // to usb core
	input  wire logic             chip_reset_out_i,            // reset-out
	input  wire logic             comm_power_request_pin_i,    // comm req
	input  wire logic             comm_status_pin_i,           // comm status
	input  wire logic             battery_fail_fast_irq_pin_i, // batt fail
	input  wire logic [OUT_W-1:0] core_out_i,                  // core outputs
	output logic      [OUT_W-1:0] pad_out_o,                   // gated outputs
	input  wire logic [IN_W-1:0]  pad_in_i,                    // pad inputs
	output logic      [IN_W-1:0]  core_in_o,                   // gated inputs
	input  wire logic [19:1]      dsp_dma_req_i,               // dsp dma reqs
	input  wire logic [30:0]      sys_dma_req_i,               // system dma
	input  wire logic [15:0]      dsp_l2_irq_i,                // dsp level-2
	input  wire logic [20:0]      dsp_l1_irq_i,                // dsp level-1
	input  wire logic [31:0]      mpu_l1_irq_i,                // mpu level-1
	input  wire logic [31:0]      mpu_l2_irq_i,                // mpu level-2
	input  wire logic             first_probe_pin_i,           // pin level in
	output logic                  first_probe_pin_o,           // pin level out
	output logic                  first_probe_pin_oe_o,        // pin enable
	output logic                  uart_rx_o,                   // to uart rx
	input  wire logic             uart_tx_i,                   // uart tx level
	input  wire logic             uart_tx_oe_i,                // uart tx enable
	output logic                  second_probe_pin_o,          // pin level out
	output logic                  second_probe_pin_oe_o        // pin enable
);

	// ****************************************************************
	// register file
	// ****************************************************************
	pgm_pkg::pgm_ctrl0_type     ctrl0_ff;
	pgm_pkg::pgm_probe_sel_type sel_ff;
	logic [31:0]                rdata_ff;
	logic [31:0]                nxt_rdata;
	logic                       session_ff;
	logic                       dma_on;
	logic                       irq_on;

	function automatic logic sel_live(input logic [6:0] sel, input logic [6:0] max);
		sel_live = (sel != 7'h00) && (sel <= max);
	endfunction

	// reserved bits are dropped on write, so stray ones never act
	// reserved 17-15 split the fields, so the word is packed by hand
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			ctrl0_ff <= `PGM_RST_CTRL0;
		else if (reg_wr_i && reg_addr_i == `PGM_OFS_CTRL0)
			ctrl0_ff <= {reg_wdata_i[`PGM_BIT_SESSION_SW], reg_wdata_i[`PGM_BIT_SESSION_SRC],
			             reg_wdata_i[`PGM_BIT_OUT_RST:`PGM_BIT_OUT_BAT]};
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			sel_ff.dma_sel <= `PGM_RST_DMA_SEL;
			sel_ff.irq_sel <= `PGM_RST_IRQ_SEL;
		end
		else if (reg_wr_i && reg_addr_i == `PGM_OFS_CTRL2)
		begin
			sel_ff.dma_sel <= reg_wdata_i[`PGM_DMA_SEL_HI:`PGM_DMA_SEL_LO];
			sel_ff.irq_sel <= reg_wdata_i[`PGM_IRQ_SEL_HI:`PGM_IRQ_SEL_LO];
		end
	end

	// control 1 holds nothing: it reads zero and ignores writes
	always_comb
	begin
		nxt_rdata = `PGM_RST_RDATA;
		case (reg_addr_i)
			`PGM_OFS_CTRL0:
			begin
				nxt_rdata[`PGM_BIT_SESSION_SW]               = ctrl0_ff.session_sw;
				nxt_rdata[`PGM_BIT_SESSION_SRC]              = ctrl0_ff.session_src;
				nxt_rdata[`PGM_BIT_OUT_RST:`PGM_BIT_OUT_BAT] = {ctrl0_ff.out_gate_rst,
					ctrl0_ff.in_gate_pwr, ctrl0_ff.out_gate_pwr, ctrl0_ff.in_gate_bat,
					ctrl0_ff.out_gate_bat};
			end
			`PGM_OFS_CTRL1:
				nxt_rdata = `PGM_RST_RDATA;
			`PGM_OFS_CTRL2:
			begin
				nxt_rdata[`PGM_DMA_SEL_HI:`PGM_DMA_SEL_LO] = sel_ff.dma_sel;
				nxt_rdata[`PGM_IRQ_SEL_HI:`PGM_IRQ_SEL_LO] = sel_ff.irq_sel;
			end
			`PGM_OFS_STATUS:
			begin
				nxt_rdata[`PGM_BIT_ST_SESSION] = session_ff;
				nxt_rdata[`PGM_BIT_ST_DMA_ON]  = dma_on;
				nxt_rdata[`PGM_BIT_ST_IRQ_ON]  = irq_on;
			end
			default:
				nxt_rdata = `PGM_RST_RDATA;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			rdata_ff <= `PGM_RST_RDATA;
		else if (reg_rd_i)
			rdata_ff <= nxt_rdata;
		else
			rdata_ff <= `PGM_RST_RDATA;
	end

	assign reg_rdata_o = rdata_ff;

	// ****************************************************************
	// usb session source
	// ****************************************************************
	// no compatibility-mode qualifier: control 0 always acts
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			session_ff <= 1'b0;
		else if (ctrl0_ff.session_src)
			session_ff <= ctrl0_ff.session_sw;
		else
			session_ff <= usb_hw_session_i;
	end

	assign usb_session_o = session_ff;

	// ****************************************************************
	// and-gating of chip inputs and outputs
	// ****************************************************************
	pgm_and_gate #(
		.W (IN_W),
		.K (3)
	) u_in_gate (
		.clk_sys_i  (clk_sys_i),
		.sys_rst_i  (sys_rst_i),
		.data_i     (pad_in_i),
		.gate_en_i  ({ctrl0_ff.in_gate_pwr, ctrl0_ff.in_gate_pwr,
		              ctrl0_ff.in_gate_bat}),
		.gate_lvl_i ({comm_power_request_pin_i, comm_status_pin_i,
		              battery_fail_fast_irq_pin_i}),
		.data_o     (core_in_o)
	);

	pgm_and_gate #(
		.W (OUT_W),
		.K (4)
	) u_out_gate (
		.clk_sys_i  (clk_sys_i),
		.sys_rst_i  (sys_rst_i),
		.data_i     (core_out_i),
		.gate_en_i  ({ctrl0_ff.out_gate_rst, ctrl0_ff.out_gate_pwr,
		              ctrl0_ff.out_gate_pwr, ctrl0_ff.out_gate_bat}),
		.gate_lvl_i ({chip_reset_out_i, comm_power_request_pin_i,
		              comm_status_pin_i, battery_fail_fast_irq_pin_i}),
		.data_o     (pad_out_o)
	);

	// ****************************************************************
	// observability probes
	// ****************************************************************
	logic [49:0]  dma_src;
	logic [100:0] irq_src;

	// bit k-1 carries selector code k
	assign dma_src = {sys_dma_req_i, dsp_dma_req_i};
	assign irq_src = {mpu_l2_irq_i, mpu_l1_irq_i, dsp_l1_irq_i, dsp_l2_irq_i};

	// first pin is normally an input, so its normal enable is low
	pgm_probe_mux #(
		.SRC_N (`PGM_DMA_SEL_MAX),
		.SEL_W (6)
	) u_dma_probe (
		.clk_sys_i  (clk_sys_i),
		.sys_rst_i  (sys_rst_i),
		.sel_i      (sel_ff.dma_sel),
		.src_i      (dma_src),
		.norm_out_i (1'b0),
		.norm_oe_i  (1'b0),
		.pin_o      (first_probe_pin_o),
		.pin_oe_o   (first_probe_pin_oe_o),
		.probe_on_o (dma_on)
	);

	// uart sees an idle line while its pin is borrowed
	assign uart_rx_o = dma_on ? 1'b1 : first_probe_pin_i;

	pgm_probe_mux #(
		.SRC_N (`PGM_IRQ_SEL_MAX),
		.SEL_W (7)
	) u_irq_probe (
		.clk_sys_i  (clk_sys_i),
		.sys_rst_i  (sys_rst_i),
		.sel_i      (sel_ff.irq_sel),
		.src_i      (irq_src),
		.norm_out_i (uart_tx_i),
		.norm_oe_i  (uart_tx_oe_i),
		.pin_o      (second_probe_pin_o),
		.pin_oe_o   (second_probe_pin_oe_o),
		.probe_on_o (irq_on)
	);

	// ****************************************************************
	// assertions
	// ****************************************************************
	logic       dma_pick;
	logic       irq_pick;
	logic [5:0] dma_idx;
	logic [6:0] irq_idx;
	logic       any_out_gate;

	assign dma_idx      = sel_ff.dma_sel - 6'h01;
	assign irq_idx      = sel_ff.irq_sel - 7'h01;
	assign dma_pick     = dma_src[dma_idx];
	assign irq_pick     = irq_src[irq_idx];
	assign any_out_gate = ctrl0_ff.out_gate_rst | ctrl0_ff.out_gate_pwr |
	                      ctrl0_ff.out_gate_bat;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_wr_ctrl2;
		reg_wr_i && reg_addr_i == `PGM_OFS_CTRL2;
	endsequence

	sequence s_rd_ctrl2;
		reg_rd_i && reg_addr_i == `PGM_OFS_CTRL2;
	endsequence

	a_session_sw_path: assert property (
		ctrl0_ff.session_src |=> usb_session_o == $past(ctrl0_ff.session_sw))
		else $error("software session level not presented");

	a_session_hw_path: assert property (
		!ctrl0_ff.session_src |=> usb_session_o == $past(usb_hw_session_i))
		else $error("hardware session level not presented");

	a_rst_out_gate: assert property (
		ctrl0_ff.out_gate_rst && !chip_reset_out_i |=> pad_out_o == '0)
		else $error("outputs not gated by reset-out");

	a_pwr_in_gate: assert property (
		ctrl0_ff.in_gate_pwr && !(comm_power_request_pin_i && comm_status_pin_i)
		|=> core_in_o == '0)
		else $error("inputs not gated by comm pins");

	a_pwr_out_gate: assert property (
		ctrl0_ff.out_gate_pwr && !(comm_power_request_pin_i && comm_status_pin_i)
		|=> pad_out_o == '0)
		else $error("outputs not gated by comm status");

	a_bat_in_gate: assert property (
		ctrl0_ff.in_gate_bat && !battery_fail_fast_irq_pin_i |=> core_in_o == '0)
		else $error("inputs not gated by battery fail");

	a_bat_out_gate: assert property (
		ctrl0_ff.out_gate_bat && !battery_fail_fast_irq_pin_i |=> pad_out_o == '0)
		else $error("outputs not gated by battery fail");

	a_out_ungated: assert property (
		!any_out_gate |=> pad_out_o == $past(core_out_i))
		else $error("outputs gated while all gating is off");

	a_in_ungated: assert property (
		!ctrl0_ff.in_gate_pwr && !ctrl0_ff.in_gate_bat |=> core_in_o == $past(pad_in_i))
		else $error("inputs gated while all gating is off");

	a_dma_probe_pin: assert property (
		sel_live({1'b0, sel_ff.dma_sel}, 7'h32)
		|=> first_probe_pin_oe_o && first_probe_pin_o == $past(dma_pick))
		else $error("dma probe pin shows wrong request");

	a_dma_sys_range: assert property (
		sel_ff.dma_sel == 6'h14 |=> first_probe_pin_o == $past(sys_dma_req_i[0]))
		else $error("dma code 20 not system request 0");

	a_irq_probe_pin: assert property (
		sel_live(sel_ff.irq_sel, 7'h65)
		|=> second_probe_pin_oe_o && second_probe_pin_o == $past(irq_pick))
		else $error("irq probe pin shows wrong line");

	a_irq_bank_edges: assert property (
		sel_ff.irq_sel == 7'h11 |=> second_probe_pin_o == $past(dsp_l1_irq_i[0]))
		else $error("irq code 17 not dsp level-1 line 0");

	a_irq_mpu_edges: assert property (
		sel_ff.irq_sel == 7'h26 |=> second_probe_pin_o == $past(mpu_l1_irq_i[0]))
		else $error("irq code 38 not mpu level-1 line 0");

	a_irq_top_code: assert property (
		sel_ff.irq_sel == 7'h65 |=> second_probe_pin_o == $past(mpu_l2_irq_i[31]))
		else $error("irq code 101 not mpu level-2 line 31");

	a_probe_out_range: assert property (
		!sel_live({1'b0, sel_ff.dma_sel}, 7'h32) |=> !first_probe_pin_oe_o ##0 !dma_on)
		else $error("illegal dma code left probe active");

	a_irq_normal: assert property (
		!sel_live(sel_ff.irq_sel, 7'h65)
		|=> second_probe_pin_o == $past(uart_tx_i) && second_probe_pin_oe_o == $past(uart_tx_oe_i))
		else $error("irq pin lost its normal function");

	a_sel_readback: assert property (
		s_wr_ctrl2 ##1 (s_rd_ctrl2 and !reg_wr_i)
		|=> reg_rdata_o[18:6] == $past(reg_wdata_i[18:6], 2))
		else $error("control 2 readback differs from write");

	a_rdata_idle: assert property (
		!reg_rd_i |=> reg_rdata_o == 32'h00000000)
		else $error("read data present without a read");

	a_reset_clear: assert property (
		@(posedge clk_sys_i) disable iff (1'b0)
		sys_rst_i |=> ctrl0_ff == '0 && sel_ff == '0 && !first_probe_pin_oe_o)
		else $error("fields not cleared by reset");

endmodule

//--- test/pgm_top_bench.sv
// self-checking bench of the pin gating and probe mux block.
// assumes pgm_top with default widths; bench drives every port itself.
`timescale 1ns/1ps
`include "pgm_defs.svh"

module pgm_top_bench;
	logic        clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i;
	logic [7:0]  reg_addr_i, core_out_i, pad_in_i, pad_out_o, core_in_o;
	logic [31:0] reg_wdata_i, reg_rdata_o, mpu_l1_irq_i, mpu_l2_irq_i, rd_val;
	logic        usb_hw_session_i, usb_session_o, chip_reset_out_i;
	logic        comm_power_request_pin_i, comm_status_pin_i, battery_fail_fast_irq_pin_i;
	logic [19:1] dsp_dma_req_i;
	logic [30:0] sys_dma_req_i;
	logic [15:0] dsp_l2_irq_i;
	logic [20:0] dsp_l1_irq_i;
	logic        first_probe_pin_i, first_probe_pin_o, first_probe_pin_oe_o, uart_rx_o;
	logic        uart_tx_i, uart_tx_oe_i, second_probe_pin_o, second_probe_pin_oe_o;
	int          n_mismatch, n_tests;

	pgm_top pgm_top_inst (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .usb_hw_session_i(usb_hw_session_i),
		.usb_session_o(usb_session_o), .chip_reset_out_i(chip_reset_out_i),
		.comm_power_request_pin_i(comm_power_request_pin_i),
		.comm_status_pin_i(comm_status_pin_i),
		.battery_fail_fast_irq_pin_i(battery_fail_fast_irq_pin_i),
		.core_out_i(core_out_i), .pad_out_o(pad_out_o), .pad_in_i(pad_in_i),
		.core_in_o(core_in_o), .dsp_dma_req_i(dsp_dma_req_i), .sys_dma_req_i(sys_dma_req_i),
		.dsp_l2_irq_i(dsp_l2_irq_i), .dsp_l1_irq_i(dsp_l1_irq_i),
		.mpu_l1_irq_i(mpu_l1_irq_i), .mpu_l2_irq_i(mpu_l2_irq_i),
		.first_probe_pin_i(first_probe_pin_i), .first_probe_pin_o(first_probe_pin_o),
		.first_probe_pin_oe_o(first_probe_pin_oe_o), .uart_rx_o(uart_rx_o),
		.uart_tx_i(uart_tx_i), .uart_tx_oe_i(uart_tx_oe_i),
		.second_probe_pin_o(second_probe_pin_o), .second_probe_pin_oe_o(second_probe_pin_oe_o)
	);

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
	begin
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	end
	endtask

	// called just after an edge; returns 1 ns after the taking edge, so the
	// next strobe follows with no gap and no double drive in one step
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
	begin
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		#1;
	end
	endtask

	// data stand only in the cycle after the strobe edge
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
	begin
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	end
	endtask

	// register value reaches the pins one edge after the write edge
	task automatic settle();
	begin
		repeat (2) @(posedge clk_sys_i);
		#1;
	end
	endtask

	task automatic set_levels(input logic [3:0] l);
	begin
		@(posedge clk_sys_i);
		{chip_reset_out_i, comm_power_request_pin_i} <= l[3:2];
		{comm_status_pin_i, battery_fail_fast_irq_pin_i} <= l[1:0];
	end
	endtask

	// only the source picked by v carries lvl, all others the inverse
	task automatic drive_src(input int v, input bit is_irq, input logic lvl);
		logic [19:1] dd;
		logic [30:0] sd;
		logic [15:0] l2;
		logic [20:0] l1;
		logic [31:0] m1, m2;
	begin
		dd = {19{~lvl}};
		sd = {31{~lvl}};
		l2 = {16{~lvl}};
		l1 = {21{~lvl}};
		m1 = {32{~lvl}};
		m2 = {32{~lvl}};
		if (!is_irq && v >= 1 && v <= 19) dd[v] = lvl;
		else if (!is_irq && v >= 20 && v <= 50) sd[v-20] = lvl;
		else if (is_irq && v >= 1 && v <= 16) l2[v-1] = lvl;
		else if (is_irq && v >= 17 && v <= 37) l1[v-17] = lvl;
		else if (is_irq && v >= 38 && v <= 69) m1[v-38] = lvl;
		else if (is_irq && v >= 70 && v <= 101) m2[v-70] = lvl;
		@(posedge clk_sys_i);
		dsp_dma_req_i <= dd;
		sys_dma_req_i <= sd;
		dsp_l2_irq_i <= l2;
		dsp_l1_irq_i <= l1;
		mpu_l1_irq_i <= m1;
		mpu_l2_irq_i <= m2;
	end
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic test_regs();
	begin
		reg_read(`PGM_OFS_CTRL0, rd_val);
		check("ctrl0 reset", rd_val, 32'h00000000);
		reg_read(`PGM_OFS_CTRL2, rd_val);
		check("ctrl2 reset", rd_val, 32'h00000000);
		reg_write(`PGM_OFS_CTRL0, 32'h000C7C00);
		reg_write(`PGM_OFS_CTRL2, 32'h0007FFC0);
		reg_read(`PGM_OFS_CTRL2, rd_val);
		check("ctrl2 fields", rd_val, 32'h0007FFC0);
		reg_write(8'h04, 32'h00000000);
		reg_write(8'h10, 32'h00000000);
		reg_read(`PGM_OFS_CTRL0, rd_val);
		check("ctrl0 fields", rd_val, 32'h000C7C00);
		reg_read(8'h04, rd_val);
		check("ctrl1 reserved", rd_val, 32'h00000000);
		@(posedge clk_sys_i);
		#1;
		check("rdata after read", reg_rdata_o, 32'h00000000);
		reg_read(8'h10, rd_val);
		check("unmapped read", rd_val, 32'h00000000);
		reg_write(`PGM_OFS_CTRL0, 32'h00000000);
		reg_write(`PGM_OFS_CTRL2, 32'h00000000);
	end
	endtask

	task automatic test_session();
	begin
		@(posedge clk_sys_i);
		usb_hw_session_i <= 1'b1;
		settle();
		check("session hw high", usb_session_o, 32'h1);
		@(posedge clk_sys_i);
		usb_hw_session_i <= 1'b0;
		reg_write(`PGM_OFS_CTRL0, 32'h000C0000);
		settle();
		check("session sw insert", usb_session_o, 32'h1);
		reg_read(`PGM_OFS_STATUS, rd_val);
		check("status session", rd_val, 32'h00000001);
		@(posedge clk_sys_i);
		usb_hw_session_i <= 1'b1;
		reg_write(`PGM_OFS_CTRL0, 32'h00040000);
		settle();
		check("session sw disconnect", usb_session_o, 32'h0);
		reg_write(`PGM_OFS_CTRL0, 32'h00000000);
		settle();
		check("session back to hw", usb_session_o, 32'h1);
	end
	endtask

	task automatic test_gating();
		int b;
		bit go, gi;
	begin
		set_levels(4'h0);
		for (b = 10; b <= 14; b++)
		begin
			reg_write(`PGM_OFS_CTRL0, 32'h1 << b);
			settle();
			go = (b == 14 || b == 12 || b == 10);
			gi = (b == 13 || b == 11);
			check("pad_out gated", pad_out_o, go ? 32'h0 : 32'hA5);
			check("core_in gated", core_in_o, gi ? 32'h0 : 32'h5A);
		end
		set_levels(4'hF);
		reg_write(`PGM_OFS_CTRL0, 32'h00007C00);
		settle();
		check("pad_out levels high", pad_out_o, 32'hA5);
		check("core_in levels high", core_in_o, 32'h5A);
		set_levels(4'hD);
		settle();
		check("pad_out comm status low", pad_out_o, 32'h00);
		check("core_in comm status low", core_in_o, 32'h00);
		set_levels(4'hB);
		settle();
		check("pad_out comm request low", pad_out_o, 32'h00);
		check("core_in comm request low", core_in_o, 32'h00);
		set_levels(4'h7);
		settle();
		check("pad_out reset-out low", pad_out_o, 32'h00);
		check("core_in reset-out low", core_in_o, 32'h5A);
		reg_write(`PGM_OFS_CTRL0, 32'h00000000);
	end
	endtask

	task automatic test_probe(input bit is_irq);
		int vals[12] = '{1, 16, 17, 19, 20, 37, 38, 50, 69, 70, 101, 102};
		int v, i, lim;
		bit on;
	begin
		lim = is_irq ? 101 : 50;
		for (i = 0; i <= 12; i++)
		begin
			v = (i == 12) ? 0 : vals[i];
			if (!is_irq && v > 63) v = 51;
			on = (v >= 1 && v <= lim);
			reg_write(`PGM_OFS_CTRL2, is_irq ? (v << 6) : (v << 13));
			// probe-active flag lags the selector by one edge
			drive_src(v, is_irq, 1'b1);
			reg_read(`PGM_OFS_STATUS, rd_val);
			check("status probe", rd_val[2:1], on ? (is_irq ? 2 : 1) : 0);
			settle();
			if (is_irq)
				check("second oe", second_probe_pin_oe_o, on);
			else
				check("first oe", first_probe_pin_oe_o, on);
			check("uart rx", uart_rx_o, !is_irq && on);
			drive_src(v, is_irq, 1'b0);
			settle();
			if (is_irq)
				check("second pin", second_probe_pin_o, !on);
			else
				check("first pin", first_probe_pin_o, 1'b0);
			drive_src(v, is_irq, 1'b1);
			settle();
			if (!is_irq)
				check("first pin high", first_probe_pin_o, on);
		end
	end
	endtask

	task automatic give_verdict();
	begin
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	// ****************************************************************
	// clock, watchdog and main sequence
	// ****************************************************************
	initial
	begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	// the whole sequence needs well under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		n_mismatch++;
		give_verdict();
	end

	initial
	begin
		n_mismatch = 0;
		n_tests = 0;
		sys_rst_i = 1'b1;
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
		{usb_hw_session_i, chip_reset_out_i, comm_power_request_pin_i} = 3'h0;
		{comm_status_pin_i, battery_fail_fast_irq_pin_i} = 2'h0;
		core_out_i = 8'hA5;
		pad_in_i = 8'h5A;
		{dsp_dma_req_i, sys_dma_req_i, dsp_l2_irq_i, dsp_l1_irq_i} = '0;
		{mpu_l1_irq_i, mpu_l2_irq_i} = '0;
		first_probe_pin_i = 1'b0;
		uart_tx_i = 1'b1;
		uart_tx_oe_i = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#1;
		check("reset outputs", {pad_out_o, core_in_o, usb_session_o}, 32'h0);
		check("reset pin oe", {first_probe_pin_oe_o, second_probe_pin_oe_o}, 32'h0);
		sys_rst_i <= 1'b0;
		test_regs();
		test_session();
		test_gating();
		test_probe(1'b0);
		test_probe(1'b1);
		give_verdict();
	end
endmodule
